// ### core/agc_control.sv
// Control core of an eight-channel sampling converter behind a two-wire target port.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "agc_params.svh"
module agc_control
  import agc_pkg::*;
#(
  parameter int unsigned HALF_US_CYCLES = `AGC_HALF_US_CYCLES,
  parameter int unsigned CAL_CYCLES = `AGC_CAL_CYCLES,
  parameter int unsigned EVAL_CYCLES = `AGC_EVAL_CYCLES,
  parameter int unsigned CONV_CYCLES = `AGC_CONV_CYCLES,
  parameter int unsigned GAP_W = 21
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Two-wire bus pins, open drain.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Address strap from the resistor decoder.
  input wire logic [2:0] bus_id_strap,
  // Converter front end.
  input wire logic [11:0] ain_code,
  output logic [2:0] ain_chan,
  output logic ain_sampling,
  output logic zero_trim_active,
  // Channel pins.
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe_n
);

  logic rst_n;
  logic soft_rst_r;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [7:0] gpio_m, gpio_s;
  logic [2:0] strap_m, strap_s;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:1] main_r;
  logic [2:0] averaging_ratio;
  logic [5:0] timing_r;
  logic [7:0] pin_function_select, io_direction, output_driver_type, output_levels;
  logic zero_trim_request;
  logic [15:0] cal_cnt_r;
  logic trig_start_r, auto_start_r, i2c_conv_r;
  logic src_trig_r;
  logic averaging_complete_flag;
  logic [15:0] eval_cnt_r;
  logic eval_busy;
  logic [6:0] taddr_r;
  logic [GAP_W-1:0] gap_cycles, ivl_cnt_r;
  logic eng_start, eng_busy, eng_done;
  logic [15:0] eng_result;
  logic [15:0] latest_result [8];
  agc_i2c_state_t st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic [23:0] tx_r;
  logic [1:0] byte_left_r;
  logic is_gc_r, is_rd_r, ack_r, gc_reset_r, gc_eval_r;
  logic tag_on, avg_on;
  logic [23:0] frame;
  logic [1:0] frame_extra;

  // The general-call reset acts like the pin reset on everything but itself.
  assign rst_n = rst_b & ~soft_rst_r;

  // The pins are only ever pulled low, so the data outputs are constant zero.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // Two flip-flops on every pin input before any logic looks at it.
  always_ff @(posedge clk_sys)
  begin
    scl_m <= scl_i;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= sda_i;
    sda_s <= sda_m;
    sda_d <= sda_s;
    gpio_m <= gpio_i;
    gpio_s <= gpio_m;
    strap_m <= bus_id_strap;
    strap_s <= strap_m;
  end

  // Edges and bus conditions, all taken from the synchronised copies.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // Software configuration registers.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      main_r <= 7'(`AGC_CFG_RST >> 1);
      averaging_ratio <= 3'h0;
      timing_r <= 6'h00;
      pin_function_select <= `AGC_CFG_RST;
      io_direction <= `AGC_CFG_RST;
      output_driver_type <= `AGC_CFG_RST;
      output_levels <= `AGC_CFG_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `AGC_REG_MAIN: main_r <= reg_wdata[7:1];
        `AGC_REG_AVG: averaging_ratio <= reg_wdata[2:0];
        `AGC_REG_TIMING: timing_r <= reg_wdata[5:0];
        `AGC_REG_PINFN: pin_function_select <= reg_wdata;
        `AGC_REG_IODIR: io_direction <= reg_wdata;
        `AGC_REG_DRV: output_driver_type <= reg_wdata;
        `AGC_REG_OUTLVL: output_levels <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign tag_on = main_r[`AGC_MAIN_TAG];
  assign avg_on = averaging_ratio != 3'h0;

  // Offset trim: a new request in the finishing cycle restarts rather than being lost.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      zero_trim_request <= 1'b0;
      cal_cnt_r <= 16'h0000;
    end
    else if (reg_wr && reg_addr == `AGC_REG_MAIN && reg_wdata[`AGC_MAIN_TRIM])
    begin
      zero_trim_request <= 1'b1;
      cal_cnt_r <= 16'(CAL_CYCLES);
    end
    else if (zero_trim_request)
    begin
      if (cal_cnt_r <= 16'h0001)
      begin
        zero_trim_request <= 1'b0;
      end
      cal_cnt_r <= cal_cnt_r - 16'h0001;
    end
  end

  assign zero_trim_active = zero_trim_request;

  // Target address: strap is caught at the end of a settle count after reset or re-evaluation.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      eval_cnt_r <= 16'(EVAL_CYCLES);
      taddr_r <= `AGC_ADDR_BASE;
    end
    else if (gc_eval_r)
    begin
      eval_cnt_r <= 16'(EVAL_CYCLES);
    end
    else if (eval_cnt_r != 16'h0000)
    begin
      eval_cnt_r <= eval_cnt_r - 16'h0001;
      if (eval_cnt_r == 16'h0001)
      begin
        taddr_r <= `AGC_ADDR_BASE | {4'h0, strap_s};
      end
    end
    else if (reg_wr && reg_addr == `AGC_REG_TADDR)
    begin
      taddr_r <= reg_wdata[6:0];
    end
  end

  assign eval_busy = eval_cnt_r != 16'h0000;

  // Start spacing: 1 or 1.5 microseconds doubled per code pair, times 32 on the slow timebase.
  always_comb
  begin
    gap_cycles = timing_r[0] ? GAP_W'(3 * HALF_US_CYCLES) : GAP_W'(2 * HALF_US_CYCLES);
    gap_cycles = gap_cycles << timing_r[3:1];
    if (timing_r[`AGC_TIM_TB])
    begin
      gap_cycles = gap_cycles << `AGC_SLOW_SHIFT;
    end
  end

  // Conversion starts: register trigger, autonomous interval, and the bus read path.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      trig_start_r <= 1'b0;
      auto_start_r <= 1'b0;
      ivl_cnt_r <= '0;
      src_trig_r <= 1'b0;
    end
    else
    begin
      trig_start_r <= reg_wr && reg_addr == `AGC_REG_TRIG && reg_wdata[0];
      auto_start_r <= 1'b0;
      if (!timing_r[`AGC_TIM_AUTO])
      begin
        ivl_cnt_r <= '0;
      end
      else if (ivl_cnt_r + 1'b1 >= gap_cycles)
      begin
        ivl_cnt_r <= '0;
        auto_start_r <= 1'b1;
      end
      else
      begin
        ivl_cnt_r <= ivl_cnt_r + 1'b1;
      end
      if (eng_start && !eng_busy)
      begin
        src_trig_r <= trig_start_r;
      end
    end
  end

  assign eng_start = trig_start_r | auto_start_r | i2c_conv_r;

  // Shared engine; a start that arrives while it runs is dropped.
  agc_conv_engine #(
    .CONV_CYCLES(CONV_CYCLES),
    .GAP_W(GAP_W)
  ) u_engine (
    .clk_sys(clk_sys),
    .rst_b(rst_n),
    .start(eng_start),
    .averaging_ratio(averaging_ratio),
    .gap_cycles(gap_cycles),
    .ain_code(ain_code),
    .busy(eng_busy),
    .sampling(ain_sampling),
    .done(eng_done),
    .result(eng_result)
  );

  // Channel is latched per conversion so a register write mid-run cannot retag it.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ain_chan <= 3'h0;
      averaging_complete_flag <= 1'b0;
    end
    else
    begin
      if (eng_start && !eng_busy)
      begin
        ain_chan <= main_r[`AGC_MAIN_CHAN_LSB+2:`AGC_MAIN_CHAN_LSB];
      end
      if (eng_done && src_trig_r && main_r[`AGC_MAIN_STATS])
      begin
        averaging_complete_flag <= 1'b1;
      end
      else if (reg_wr && reg_addr == `AGC_REG_STATUS && reg_wdata[`AGC_STAT_AVG_DONE])
      begin
        averaging_complete_flag <= 1'b0;
      end
    end
  end

  // Per-channel result store, left-justified so plain and averaged codes share one format.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        latest_result[i] <= 16'h0000;
      end
    end
    else if (eng_done)
    begin
      latest_result[ain_chan] <= eng_result;
    end
  end

  // Outgoing bytes: value high first, tag in the nibble after a 12-bit value or a third byte.
  always_comb
  begin
    frame = {eng_result, 8'h00};
    frame_extra = 2'h1;
    if (tag_on && !avg_on)
    begin
      frame[11:8] = {1'b0, ain_chan};
    end
    else if (tag_on)
    begin
      frame[7:0] = {1'b0, ain_chan, 4'h0};
      frame_extra = 2'h2;
    end
  end

  // Register read data, valid only in the cycle after the strobe.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !reg_rd)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_addr[7:6] == `AGC_RES_WINDOW)
    begin
      reg_rdata <= reg_addr[2] ? latest_result[reg_addr[5:3]][15:8] :
                   latest_result[reg_addr[5:3]][7:0];
    end
    else
    begin
      unique case (reg_addr)
        `AGC_REG_MAIN: reg_rdata <= {main_r, zero_trim_request};
        `AGC_REG_AVG: reg_rdata <= {5'h00, averaging_ratio};
        `AGC_REG_TIMING: reg_rdata <= {2'h0, timing_r};
        `AGC_REG_PINFN: reg_rdata <= pin_function_select;
        `AGC_REG_IODIR: reg_rdata <= io_direction;
        `AGC_REG_DRV: reg_rdata <= output_driver_type;
        `AGC_REG_OUTLVL: reg_rdata <= output_levels;
        `AGC_REG_INLVL: reg_rdata <= gpio_s & pin_function_select & ~io_direction;
        `AGC_REG_STATUS: reg_rdata <= {5'h00, eval_busy, eng_busy, averaging_complete_flag};
        `AGC_REG_TADDR: reg_rdata <= {1'b0, taddr_r};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Channel pins: an open-drain high is released, push-pull drives both levels.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      gpio_o <= 8'h00;
      gpio_oe_n <= 8'hFF;
    end
    else
    begin
      gpio_o <= output_levels;
      gpio_oe_n <= ~(pin_function_select & io_direction &
                     (output_driver_type | ~output_levels));
    end
  end

  // The general-call reset pulse itself only answers to the pin reset.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      soft_rst_r <= 1'b0;
    end
    else
    begin
      soft_rst_r <= gc_reset_r;
    end
  end

  // Two-wire target port; data changes only while the clock is low.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= I2C_IDLE;
      bit_cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 24'h000000;
      byte_left_r <= 2'h0;
      is_gc_r <= 1'b0;
      is_rd_r <= 1'b0;
      ack_r <= 1'b0;
      gc_reset_r <= 1'b0;
      gc_eval_r <= 1'b0;
      i2c_conv_r <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      i2c_conv_r <= 1'b0;
      gc_reset_r <= 1'b0;
      gc_eval_r <= 1'b0;
      if (bus_stop)
      begin
        st_r <= I2C_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (bus_start)
      begin
        st_r <= I2C_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else
      begin
        unique case (st_r)
          I2C_IDLE: ;
          I2C_ADDR, I2C_WR_BYTE:
          begin
            if (scl_rise)
            begin
              rx_r <= {rx_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (scl_fall && bit_cnt_r == 4'h8)
            begin
              bit_cnt_r <= 4'h0;
              if (st_r == I2C_WR_BYTE)
              begin
                sda_oe_n <= 1'b0;
                st_r <= I2C_WR_ACK;
              end
              else if (rx_r == `AGC_GC_ADDR)
              begin
                is_gc_r <= 1'b1;
                is_rd_r <= 1'b0;
                sda_oe_n <= 1'b0;
                st_r <= I2C_ADDR_ACK;
              end
              else if (rx_r[7:1] == taddr_r && !eval_busy)
              begin
                is_gc_r <= 1'b0;
                is_rd_r <= rx_r[0];
                sda_oe_n <= 1'b0;
                st_r <= I2C_ADDR_ACK;
              end
              else
              begin
                st_r <= I2C_IDLE;
              end
            end
          end
          I2C_ADDR_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_n <= 1'b1;
              if (is_rd_r)
              begin
                i2c_conv_r <= 1'b1;
                scl_oe_n <= 1'b0;
                st_r <= I2C_STRETCH;
              end
              else
              begin
                st_r <= I2C_WR_BYTE;
              end
            end
          end
          I2C_WR_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_n <= 1'b1;
              st_r <= I2C_WR_BYTE;
              gc_reset_r <= is_gc_r && rx_r == `AGC_GC_RESET;
              gc_eval_r <= is_gc_r && rx_r == `AGC_GC_READDR;
            end
          end
          I2C_STRETCH:
          begin
            if (eng_done)
            begin
              tx_r <= frame;
              byte_left_r <= frame_extra;
              sda_oe_n <= frame[23];
              bit_cnt_r <= 4'h1;
              st_r <= I2C_RD_BYTE;
            end
          end
          I2C_RD_BYTE:
          begin
            // The clock goes free a cycle after the first bit is set, so data lead its rise.
            scl_oe_n <= 1'b1;
            if (scl_fall)
            begin
              tx_r <= {tx_r[22:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
              sda_oe_n <= (bit_cnt_r == 4'h8) ? 1'b1 : tx_r[22];
              if (bit_cnt_r == 4'h8)
              begin
                st_r <= I2C_RD_ACK;
              end
            end
          end
          I2C_RD_ACK:
          begin
            if (scl_rise)
            begin
              ack_r <= ~sda_s;
            end
            else if (scl_fall)
            begin
              if (!ack_r)
              begin
                st_r <= I2C_IDLE;
              end
              else if (byte_left_r != 2'h0)
              begin
                byte_left_r <= byte_left_r - 2'h1;
                sda_oe_n <= tx_r[23];
                bit_cnt_r <= 4'h1;
                st_r <= I2C_RD_BYTE;
              end
              else
              begin
                i2c_conv_r <= 1'b1;
                scl_oe_n <= 1'b0;
                st_r <= I2C_STRETCH;
              end
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### core/agc_conv_engine.sv
// Conversion and averaging engine: runs one or 2**ratio conversions and scales the sum.
`timescale 1ns/1ps
`default_nettype none
`include "agc_params.svh"
module agc_conv_engine
  import agc_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `AGC_CONV_CYCLES,
  parameter int unsigned GAP_W = 21
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control.
  input wire logic start,
  input wire logic [2:0] averaging_ratio,
  input wire logic [GAP_W-1:0] gap_cycles,
  // Converter front end.
  input wire logic [11:0] ain_code,
  // Results.
  output logic busy,
  output logic sampling,
  output logic done,
  output logic [15:0] result
);

  agc_eng_state_t st_r;
  logic [GAP_W-1:0] cnt_r;
  logic [7:0] left_r;
  logic [18:0] acc_r;
  logic [2:0] ratio_r;
  logic [22:0] scaled;

  // Sum shifted up to 16 bits then divided by the sample count; ratio 0 leaves the single code shifted up by four.
  assign scaled = {acc_r, 4'h0} >> ratio_r;

  // Conversion time is a fixed count; the rate setting only spaces the starts apart.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_r <= ENG_IDLE;
      cnt_r <= '0;
      left_r <= 8'h00;
      acc_r <= '0;
      ratio_r <= 3'h0;
      busy <= 1'b0;
      sampling <= 1'b0;
      done <= 1'b0;
      result <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      unique case (st_r)
        ENG_IDLE:
        begin
          if (start)
          begin
            st_r <= ENG_CONV;
            cnt_r <= '0;
            left_r <= 8'h01 << averaging_ratio;
            ratio_r <= averaging_ratio;
            acc_r <= '0;
            busy <= 1'b1;
            sampling <= 1'b1;
          end
        end
        ENG_CONV:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == GAP_W'(CONV_CYCLES - 1))
          begin
            acc_r <= acc_r + {7'h00, ain_code};
            left_r <= left_r - 8'h01;
            sampling <= 1'b0;
            st_r <= (left_r == 8'h01) ? ENG_FINISH : ENG_WAIT;
          end
        end
        ENG_WAIT:
        begin
          // Further samples are started here, without any host action.
          if (cnt_r + 1'b1 >= gap_cycles)
          begin
            cnt_r <= '0;
            sampling <= 1'b1;
            st_r <= ENG_CONV;
          end
          else
          begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ENG_FINISH:
        begin
          result <= scaled[15:0];
          done <= 1'b1;
          busy <= 1'b0;
          st_r <= ENG_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### core/agc_params.svh
// Constants for the converter control core: register map, field positions, reset values, timing.
`ifndef AGC_PARAMS_SVH
`define AGC_PARAMS_SVH

// Register byte addresses on the register port.
`define AGC_REG_MAIN 8'h00
`define AGC_REG_AVG 8'h04
`define AGC_REG_TIMING 8'h08
`define AGC_REG_PINFN 8'h0C
`define AGC_REG_IODIR 8'h10
`define AGC_REG_DRV 8'h14
`define AGC_REG_OUTLVL 8'h18
`define AGC_REG_INLVL 8'h1C
`define AGC_REG_TRIG 8'h20
`define AGC_REG_STATUS 8'h24
`define AGC_REG_TADDR 8'h28
// Result window: address bits [7:6] equal to this, channel in [5:3], high byte when [2] set.
`define AGC_RES_WINDOW 2'h1

// Field positions.
`define AGC_MAIN_TRIM 0
`define AGC_MAIN_TAG 1
`define AGC_MAIN_STATS 2
`define AGC_MAIN_CHAN_LSB 4
`define AGC_TIM_TB 4
`define AGC_TIM_AUTO 5
`define AGC_STAT_AVG_DONE 0

// Reset values.
`define AGC_CFG_RST 8'h00
`define AGC_ADDR_BASE 7'h10

// Bus codes.
`define AGC_GC_ADDR 8'h00
`define AGC_GC_RESET 8'h06
`define AGC_GC_READDR 8'h04

// Timing: clock period and times in their own units, then derived cycle counts.
`define AGC_CLK_PERIOD_PS 5000
`define AGC_HALF_US_PS 500000
`define AGC_HALF_US_CYCLES ((`AGC_HALF_US_PS) / (`AGC_CLK_PERIOD_PS))
`define AGC_SLOW_SHIFT 5
`define AGC_CONV_NS 1000
`define AGC_CONV_CYCLES ((`AGC_CONV_NS * 1000 + `AGC_CLK_PERIOD_PS - 1) / `AGC_CLK_PERIOD_PS)
`define AGC_CAL_NS 10000
`define AGC_CAL_CYCLES ((`AGC_CAL_NS * 1000 + `AGC_CLK_PERIOD_PS - 1) / `AGC_CLK_PERIOD_PS)
`define AGC_EVAL_NS 1000
`define AGC_EVAL_CYCLES ((`AGC_EVAL_NS * 1000 + `AGC_CLK_PERIOD_PS - 1) / `AGC_CLK_PERIOD_PS)

`endif

// ### core/agc_pkg.sv
// Types shared by the converter control core.
package agc_pkg;

  // Two-wire target port states.
  typedef enum logic [7:0] {
    I2C_IDLE = 8'h01,
    I2C_ADDR = 8'h02,
    I2C_ADDR_ACK = 8'h04,
    I2C_WR_BYTE = 8'h08,
    I2C_WR_ACK = 8'h10,
    I2C_STRETCH = 8'h20,
    I2C_RD_BYTE = 8'h40,
    I2C_RD_ACK = 8'h80
  } agc_i2c_state_t;

  // Conversion engine states.
  typedef enum logic [3:0] {
    ENG_IDLE = 4'h1,
    ENG_CONV = 4'h2,
    ENG_WAIT = 4'h4,
    ENG_FINISH = 4'h8
  } agc_eng_state_t;

endpackage

// ### dv/agc_control_props.sv
// Port checker for the converter control core.
`timescale 1ns/1ps
`default_nettype none
module agc_control_props
#(
  parameter int unsigned CONV_CYCLES = 10
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins.
  input wire logic scl_i,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic ain_sampling,
  input wire logic zero_trim_active,
  input wire logic [7:0] gpio_o,
  input wire logic [7:0] gpio_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic [15:0] samp_cnt_r;
  // Length of the running sample pulse, judged when the pulse ends.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !ain_sampling)
      samp_cnt_r <= 16'h0000;
    else
      samp_cnt_r <= samp_cnt_r + 16'h0001;
  end
  a_pins_default: assert property (
    $rose(rst_b) |-> gpio_oe_n == 8'hFF && gpio_o == 8'h00) else $error("pins driven at reset");
  a_level_copy: assert property (
    reg_wr && reg_addr == 8'h18 |-> ##2 gpio_o == $past(reg_wdata, 2)) else $error("gpio_o stale");
  a_trim_clears: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[0] |=> zero_trim_active ##[1:40] !zero_trim_active)
    else $error("trim never ends");
  a_conv_length: assert property (
    $fell(ain_sampling) |-> samp_cnt_r == 16'(CONV_CYCLES)) else $error("bad conversion length");
  a_trig_no_hold: assert property (
    reg_wr && reg_addr == 8'h20 && reg_wdata[0] |=> scl_oe_n [*8]) else $error("clock held");
  a_hold_covers: assert property (
    $rose(scl_oe_n) |-> !ain_sampling) else $error("clock freed mid conversion");
  a_hold_bounded: assert property (
    $fell(scl_oe_n) |-> ##[1:300] $rose(scl_oe_n)) else $error("clock held too long");
  a_data_stable: assert property (
    $changed(sda_oe_n) |-> !scl_i) else $error("data moved with clock high");
  a_rd_idle_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
endmodule
bind agc_control agc_control_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i,
  .scl_oe_n, .sda_oe_n, .ain_sampling, .zero_trim_active, .gpio_o, .gpio_oe_n);
`default_nettype wire

// ### dv/agc_host_bfm.sv
// Two-wire bus controller model standing on the host side.
`timescale 1ns/1ps
`default_nettype none
module agc_host_bfm
(
  // Wire levels.
  input wire logic scl_w,
  input wire logic sda_w,
  // Own pulls; 1 leaves the line to the pull-up.
  output var logic m_scl,
  output var logic m_sda
);
  // Set when a stretched clock never came back; the bench counts it as a mismatch.
  logic stuck;
  initial
  begin
    m_scl = 1'b1;
    m_sda = 1'b1;
    stuck = 1'b0;
  end
  // Data moves only while the clock is low; the target may stretch, so wait boundedly.
  task automatic bit_io(input logic b, output logic r);
    int n;
    m_sda = b;
    #16;
    m_scl = 1'b1;
    n = 0;
    while (scl_w !== 1'b1 && n < 4000)
    begin
      #1;
      n++;
    end
    if (n == 4000)
      stuck = 1'b1;
    #32;
    r = sda_w;
    m_scl = 1'b0;
    #16;
  endtask
  task automatic start();
    #32;
    m_sda = 1'b0;
    #32;
    m_scl = 1'b0;
  endtask
  task automatic stop();
    m_sda = 1'b0;
    #16;
    m_scl = 1'b1;
    #32;
    m_sda = 1'b1;
    #32;
  endtask
  // Eight bits, most significant first, then the ninth acknowledge bit.
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the converter control core.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rst_b, reg_wr, reg_rd, scl_w, sda_w, m_scl, m_sda, ack, zero_trim_active;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, ain_sampling;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, gpio_i, gpio_o, gpio_oe_n, q;
  logic [11:0] ain_code;
  logic [2:0] bus_id_strap;
  int failures = 0;
  int n_checks = 0;
  agc_host_bfm hst (.scl_w, .sda_w, .m_scl, .m_sda);
  // Open-drain wires: whoever pulls low wins.
  assign scl_w = m_scl & (scl_oe_n | scl_o);
  assign sda_w = m_sda & (sda_oe_n | sda_o);
  agc_control #(.HALF_US_CYCLES(4), .CAL_CYCLES(20), .EVAL_CYCLES(8), .CONV_CYCLES(10)) dut_u (
    .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i(scl_w),
    .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o, .sda_oe_n, .bus_id_strap, .ain_code,
    .ain_chan(), .ain_sampling, .zero_trim_active, .gpio_i, .gpio_o, .gpio_oe_n);
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0 && !hst.stuck)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so take them mid-cycle.
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input bit cmp = 1'b1);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    q = reg_rdata;
    if (cmp)
      check($sformatf("reg %h", a), q, e);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      rc(a, 8'h00, 1'b0);
      n++;
    end
    while (q[b] !== v && n < 200);
    check($sformatf("poll %h", a), q[b], v);
    if (n == 200)
      wrap_up();
  endtask
  // Address byte, then n bytes read; the last one is refused to end the frame.
  task automatic fr(input logic [7:0] a, input int n, input logic [23:0] e);
    hst.start();
    hst.byte_io(a, 1'b1, q, ack);
    check("addr ack", ack, n == 0);
    for (int i = 0; i < n; i++)
    begin
      hst.byte_io(8'hFF, i == n - 1, q, ack);
      check("bus byte", q, e[8*(n-1-i) +: 8]);
    end
    hst.stop();
    check("scl stuck", hst.stuck, 1'b0);
    if (hst.stuck)
      wrap_up();
  endtask
  task automatic t_gpio();
    wr(8'h0C, 8'hFF);
    wr(8'h10, 8'h0F);
    wr(8'h14, 8'h05);
    wr(8'h18, 8'hAF);
    gpio_i <= 8'h3C;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("gpio_oe_n", gpio_oe_n, 8'hFA);
    check("gpio_o", gpio_o, 8'hAF);
    rc(8'h1C, 8'h30);
    wr(8'h0C, 8'h00);
    repeat (2) @(negedge clk_sys);
    check("gpio_oe_n", gpio_oe_n, 8'hFF);
  endtask
  task automatic t_trig();
    ain_code <= 12'hABC;
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h34);
    wr(8'h20, 8'h01);
    poll(8'h24, 0, 1'b1);
    rc(8'h5C, 8'hAB);
    rc(8'h58, 8'hC0);
    wr(8'h24, 8'h01);
    rc(8'h24, 8'h00);
  endtask
  task automatic t_trim();
    wr(8'h00, 8'h01);
    @(negedge clk_sys);
    check("trim", zero_trim_active, 1'b1);
    poll(8'h00, 0, 1'b0);
  endtask
  task automatic t_bus();
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h52);
    ain_code <= 12'hFFF;
    fr(8'h27, 3, 24'hFFF050);
    wr(8'h04, 8'h00);
    ain_code <= 12'h800;
    fr(8'h27, 2, 24'h008005);
    @(posedge clk_sys);
    ain_code <= 12'h000;
    fr(8'h27, 2, 24'h000005);
    fr(8'h21, 0, 24'h000000);
  endtask
  // Cycles from one autonomous start to the next, between rises of the sampling pulse.
  task automatic t_rate(input logic [7:0] cfg, input int e);
    int n, m;
    wr(8'h08, cfg);
    n = 0;
    m = 0;
    for (int k = 0; k < 2; k++)
    begin
      m = n;
      while (ain_sampling && n < 1200)
      begin
        @(negedge clk_sys);
        n++;
      end
      while (!ain_sampling && n < 1200)
      begin
        @(negedge clk_sys);
        n++;
      end
    end
    check("start gap", 16'(n - m), 16'(e));
    if (n == 1200)
      wrap_up();
    wr(8'h08, 8'h00);
  endtask
  // General call with one command byte, then time for the command to act.
  task automatic gcall(input logic [7:0] c);
    hst.start();
    hst.byte_io(8'h00, 1'b1, q, ack);
    check("gc ack", ack, 1'b0);
    hst.byte_io(c, 1'b1, q, ack);
    hst.stop();
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic t_gc();
    @(posedge clk_sys);
    bus_id_strap <= 3'h5;
    repeat (4) @(posedge clk_sys);
    rc(8'h28, 8'h13);
    gcall(8'h04);
    rc(8'h28, 8'h15);
    gcall(8'h06);
    rc(8'h00, 8'h00);
    rc(8'h28, 8'h15);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, gpio_i, ain_code} = '0;
    bus_id_strap = 3'h3;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk_sys);
    wr(8'h3C, 8'hFF);
    rc(8'h3C, 8'h00);
    rc(8'h28, 8'h13);
    t_gpio();
    t_trig();
    t_trim();
    wr(8'h04, 8'h00);
    t_rate(8'h23, 24);
    t_rate(8'h30, 256);
    t_bus();
    t_gc();
    wrap_up();
  end
endmodule
`default_nettype wire
